/* File: mlc_ctrl.sv */
// Low-speed control of an optical module: 2-wire slave, reset sequencing, interrupts and register bus.
//
// Added by the designer: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
`include "mlc_regs.svh"
// Summary of operation
// - Answer 2-wire traffic only while module select is held low.
// - Reset pin low beyond minimum pulse returns all settings to defaults.
// - At reset end clear data-not-ready first, then assert the interrupt.
// - Power-up raises the same reset-complete interrupt without a reset pulse.
// - Interrupt pin goes low for faults or critical status.
// - Interrupt pin only pulls low; the host supplies the pull-up.
// - Transmitter off when the pin or the serial control bit asks.
// - Loss-of-signal alarm when any received lane is below threshold.
// - Each received lane level is readable over 2-wire.
// - Low-power input selects the permitted power limit.
// - Presence line is tied to ground while the module is inserted.
// - Seven low-speed signals: select, clock, data, reset, low power, presence, interrupt.
// - Fully functional at most 2000 ms after power is good.
module mlc_ctrl #(
  parameter int unsigned INIT_CYCLES = `MLC_INIT_CYC,
  parameter int unsigned RST_MIN_CYCLES = `MLC_RST_MIN_CYC,
  parameter logic [6:0] DEV_ADDR = `MLC_TW_ADDR,
  parameter int LANES = 4
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  output logic irq,
  input wire logic module_select_n,
  input wire logic module_reset_n,
  input wire logic low_power_request,
  input wire logic transmit_disable,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic module_present_n_o,
  output logic module_present_n_oe,
  input wire logic module_irq_n_i,
  output logic module_irq_n_o,
  output logic module_irq_n_oe,
  output logic tx_output_off,
  output logic power_limit_low,
  output logic receive_signal_loss,
  input wire logic [LANES*8-1:0] rx_level_flat
);
  logic [6:0] pin_s;
  logic scl_s, sda_s, sel_n_s, rst_n_s, transmit_disable_s, lpm_s, irq_line_n_s;
  logic dev_rst, init_done, dnr;
  logic scl_d_r, sda_d_r;
  logic scl_rise, scl_fall, start_c, stop_c;
  mlc_pkg::mlc_tw_state_t state_r;
  logic [3:0] bitcnt_r;
  logic [7:0] shift_r, tx_r, tw_rdata;
  logic [2:0] ptr_r;
  logic ptr_valid_r, rw_r, sda_oe_r, flag_rd_clr;
  logic tw_we_r;
  logic [2:0] tw_wadr_r;
  logic [7:0] tw_wdat_r;
  logic ctrl_txdis_r;
  logic [7:0] thr_r;
  logic [`MLC_EV_W-1:0] istat_r, imask_r, ev;
  logic [`MLC_HF_W-1:0] hflag_r;
  logic [LANES-1:0] lane_loss;
  logic los_r, los_rise, irq_pin_r, ack_r, wb_req, wb_wr;

  // Seven low-speed signals. Every pin from the host passes two flops before any logic reads it.
  mlc_sync #(.W(7), .INIT(7'h7F)) u_sync (
    .clk_sys(clk_sys),
    .srst(srst),
    .d_i({scl_in, sda_in, module_select_n, module_reset_n, transmit_disable, low_power_request, module_irq_n_i}),
    .q_o(pin_s)
  );
  assign {scl_s, sda_s, sel_n_s, rst_n_s, transmit_disable_s, lpm_s, irq_line_n_s} = pin_s;

  // Reset pin filter and power-up timer; srst plays the part of power-good.
  mlc_init #(.INIT_CYCLES(INIT_CYCLES), .RST_MIN_CYCLES(RST_MIN_CYCLES)) u_init (
    .clk_sys(clk_sys),
    .srst(srst),
    .reset_n_s(rst_n_s),
    .dev_rst(dev_rst),
    .init_done(init_done),
    .data_not_ready(dnr)
  );

  // Edge finding on the sampled serial clock and data.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end
  assign scl_rise = scl_s && !scl_d_r;
  assign scl_fall = !scl_s && scl_d_r;
  assign start_c = scl_s && scl_d_r && sda_d_r && !sda_s;
  assign stop_c = scl_s && scl_d_r && !sda_d_r && sda_s;

  // Presence grounded. The line is pulled low for as long as the module sits in its slot.
  assign module_present_n_o = 1'b0;
  assign module_present_n_oe = 1'b1;
  // Open-drain pins. Data and interrupt only ever pull low.
  assign sda_out = 1'b0;
  assign module_irq_n_o = 1'b0;
  assign sda_oe = sda_oe_r;
  assign module_irq_n_oe = irq_pin_r;

  // Serial read map: status, flags, lane loss, control and lane levels.
  always_comb begin
    tw_rdata = 8'h00;
    if (ptr_r[2]) begin
      tw_rdata = rx_level_flat[ptr_r[1:0]*8 +: 8];
    end else if (ptr_r == `MLC_TW_STAT) begin
      tw_rdata = {7'h00, dnr};
    end else if (ptr_r == `MLC_TW_FLAGS) begin
      tw_rdata = {6'h00, hflag_r};
    end else if (ptr_r == `MLC_TW_LOSS) begin
      tw_rdata = 8'(lane_loss);
    end else begin
      tw_rdata = {7'h00, ctrl_txdis_r};
    end
  end

  // Select gating. A raised select or a stop drops any transfer in flight.
  always_ff @(posedge clk_sys) begin
    tw_we_r <= 1'b0;
    flag_rd_clr <= 1'b0;
    if (srst || sel_n_s || stop_c) begin
      state_r <= mlc_pkg::TW_IDLE;
      sda_oe_r <= 1'b0;
      bitcnt_r <= 4'h0;
      ptr_valid_r <= 1'b0;
      rw_r <= 1'b0;
      if (srst) begin
        ptr_r <= 3'h0;
        shift_r <= 8'h00;
        tx_r <= 8'hFF;
        tw_wadr_r <= 3'h0;
        tw_wdat_r <= 8'h00;
      end
    end else if (start_c) begin
      state_r <= mlc_pkg::TW_DEV;
      sda_oe_r <= 1'b0;
      bitcnt_r <= 4'h0;
      ptr_valid_r <= 1'b0;
      rw_r <= 1'b0;
    end else begin
      unique case (state_r)
        mlc_pkg::TW_IDLE: begin
          sda_oe_r <= 1'b0;
        end
        mlc_pkg::TW_DEV, mlc_pkg::TW_WR: begin
          if (scl_rise) begin
            shift_r <= {shift_r[6:0], sda_s};
            bitcnt_r <= bitcnt_r + 4'h1;
          end else if (scl_fall && bitcnt_r == 4'h8) begin
            bitcnt_r <= 4'h0;
            if (state_r == mlc_pkg::TW_DEV) begin
              // Only our own address is acknowledged.
              state_r <= (shift_r[7:1] == DEV_ADDR) ? mlc_pkg::TW_ACK : mlc_pkg::TW_IDLE;
              sda_oe_r <= (shift_r[7:1] == DEV_ADDR);
              rw_r <= shift_r[0];
            end else begin
              state_r <= mlc_pkg::TW_ACK;
              sda_oe_r <= 1'b1;
              if (!ptr_valid_r) begin
                ptr_r <= shift_r[2:0];
                ptr_valid_r <= 1'b1;
              end else begin
                tw_we_r <= 1'b1;
                tw_wadr_r <= ptr_r;
                tw_wdat_r <= shift_r;
                ptr_r <= ptr_r + 3'h1;
              end
            end
          end
        end
        mlc_pkg::TW_ACK: begin
          if (scl_fall) begin
            bitcnt_r <= 4'h0;
            if (rw_r) begin
              state_r <= mlc_pkg::TW_RD;
              tx_r <= tw_rdata;
              sda_oe_r <= !tw_rdata[7];
              ptr_r <= ptr_r + 3'h1;
              flag_rd_clr <= (ptr_r == `MLC_TW_FLAGS);
            end else begin
              state_r <= mlc_pkg::TW_WR;
              sda_oe_r <= 1'b0;
            end
          end
        end
        mlc_pkg::TW_RD: begin
          if (scl_rise) begin
            bitcnt_r <= bitcnt_r + 4'h1;
          end else if (scl_fall && bitcnt_r == 4'h8) begin
            state_r <= mlc_pkg::TW_RACK;
            sda_oe_r <= 1'b0;
            bitcnt_r <= 4'h0;
          end else if (scl_fall) begin
            sda_oe_r <= !tx_r[6];
            tx_r <= {tx_r[6:0], 1'b1};
          end
        end
        mlc_pkg::TW_RACK: begin
          // A not-acknowledge ends the read; an acknowledge fetches the next byte.
          if (scl_rise && sda_s) begin
            state_r <= mlc_pkg::TW_IDLE;
          end else if (scl_fall) begin
            state_r <= mlc_pkg::TW_RD;
            tx_r <= tw_rdata;
            sda_oe_r <= !tw_rdata[7];
            ptr_r <= ptr_r + 3'h1;
            flag_rd_clr <= (ptr_r == `MLC_TW_FLAGS);
          end
        end
        default: begin
          state_r <= mlc_pkg::TW_IDLE;
          sda_oe_r <= 1'b0;
        end
      endcase
    end
  end

  // Lane loss detect. Each lane level is compared with the threshold.
  for (genvar i = 0; i < LANES; i++) begin : g_lane
    assign lane_loss[i] = rx_level_flat[i*8 +: 8] < thr_r;
  end
  assign los_rise = (|lane_loss) && !los_r;

  // Transmitter disable. Either source turns the output off; power limit follows the pin.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      los_r <= 1'b0;
      tx_output_off <= 1'b1;
      power_limit_low <= 1'b1;
    end else begin
      los_r <= |lane_loss;
      tx_output_off <= transmit_disable_s || ctrl_txdis_r;
      power_limit_low <= lpm_s;
    end
  end
  assign receive_signal_loss = los_r;

  // Settings to defaults. A serial write wins over a bus write in the same cycle.
  always_ff @(posedge clk_sys) begin
    if (srst || dev_rst) begin
      ctrl_txdis_r <= 1'b0;
      thr_r <= `MLC_THR_RST;
      imask_r <= '0;
    end else if (tw_we_r && tw_wadr_r == `MLC_TW_CTRL) begin
      ctrl_txdis_r <= tw_wdat_r[`MLC_CTRL_TXDIS];
    end else if (wb_wr) begin
      if (wb_adr_i == `MLC_WB_CTRL) begin
        ctrl_txdis_r <= wb_dat_i[`MLC_CTRL_TXDIS];
      end
      if (wb_adr_i == `MLC_WB_THR) begin
        thr_r <= wb_dat_i[7:0];
      end
      if (wb_adr_i == `MLC_WB_IMASK) begin
        imask_r <= wb_dat_i[`MLC_EV_W-1:0];
      end
    end
  end

  // Interrupt pin. Loss and done flags; a read clears only the bits it reported, so a late event survives.
  always_ff @(posedge clk_sys) begin
    if (srst || dev_rst) begin
      hflag_r <= '0;
      irq_pin_r <= 1'b0;
    end else begin
      hflag_r <= (hflag_r & ~(flag_rd_clr ? tx_r[`MLC_HF_W-1:0] : '0)) | {los_rise, init_done};
      irq_pin_r <= |hflag_r;
    end
  end

  // Internal events for firmware: set wins over a write-one clear.
  assign ev[`MLC_EV_DONE] = init_done;
  assign ev[`MLC_EV_LOS] = los_rise;
  assign ev[`MLC_EV_HOST] = tw_we_r;
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      istat_r <= '0;
      irq <= 1'b0;
    end else begin
      istat_r <= (istat_r & ~((wb_wr && wb_adr_i == `MLC_WB_ISTAT) ? wb_dat_i[`MLC_EV_W-1:0] : '0)) | ev;
      irq <= |(istat_r & imask_r);
    end
  end

  // Classic single-cycle slave: ack one cycle after the strobe, unmapped reads give zero.
  assign wb_req = wb_cyc_i && wb_stb_i && !ack_r;
  assign wb_wr = wb_req && wb_we_i && wb_sel_i[0];
  assign wb_ack_o = ack_r;
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ack_r <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      ack_r <= wb_req;
      if (wb_req) begin
        unique case (wb_adr_i)
          `MLC_WB_CTRL: wb_dat_o <= {31'h0, ctrl_txdis_r};
          `MLC_WB_STAT: wb_dat_o <= {20'h0, 4'(lane_loss), 3'h0, !irq_line_n_s, los_r, tx_output_off,
            power_limit_low, dnr};
          `MLC_WB_ISTAT: wb_dat_o <= 32'(istat_r);
          `MLC_WB_IMASK: wb_dat_o <= 32'(imask_r);
          `MLC_WB_THR: wb_dat_o <= {24'h0, thr_r};
          default: wb_dat_o <= 32'h0;
        endcase
      end
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  a_ignore_unsel: assert property ($past(sel_n_s) |-> !sda_oe_r)
    else $error("Data line driven while deselected.");
  a_done_order: assert property (init_done |-> !dnr ##1 hflag_r[0] ##1 module_irq_n_oe)
    else $error("Reset-complete interrupt out of order.");
  a_irq_follow: assert property (!$past(dev_rst) |-> module_irq_n_oe == $past(|hflag_r))
    else $error("Interrupt pin does not follow the flags.");
  a_flag_clear: assert property (flag_rd_clr && !los_rise && !init_done && hflag_r == tx_r[`MLC_HF_W-1:0]
    |=> hflag_r == '0 ##1 !module_irq_n_oe)
    else $error("Flags not released after the host read.");
  a_tx_off: assert property (tx_output_off == $past(transmit_disable_s || ctrl_txdis_r))
    else $error("Transmitter state does not match the disable sources.");
  a_los_alarm: assert property (receive_signal_loss == $past(|lane_loss))
    else $error("Loss alarm does not match the lanes.");
  a_power_lim: assert property (power_limit_low == $past(lpm_s))
    else $error("Power limit does not follow the low-power input.");
  a_wb_ack_one: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("Bus acknowledge held longer than one cycle.");
endmodule // mlc_ctrl

/* File: mlc_ctrl_tb.sv */
// Self-checking bench for the module control block.
`timescale 1ns/1ps
`include "mlc_regs.svh"
module mlc_ctrl_tb;
  localparam int unsigned INIT_N = 50;
  localparam int unsigned RMIN_N = 5;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0] wb_sel_i = 4'hF;
  logic wb_we_i = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic module_select_n = 1'b1;
  logic module_reset_n = 1'b1;
  logic low_power_request = 1'b0;
  logic transmit_disable = 1'b0;
  logic [31:0] rx_level_flat = 32'h80808080;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, irq, scl_in, sda_in, sda_out, sda_oe, tx_output_off, power_limit_low, receive_signal_loss;
  logic module_irq_n_i, module_irq_n_o, module_irq_n_oe, module_present_n_o, module_present_n_oe;
  int bad_count = 0;
  int comparisons = 0;
  logic [31:0] q;
  logic [7:0] sb;
  logic ok;

  mlc_ctrl #(.INIT_CYCLES(INIT_N), .RST_MIN_CYCLES(RMIN_N)) dut (.*);
  mlc_host_model #(.DEV_ADDR(`MLC_TW_ADDR)) host (.*);

  // Clock of 20 ns.
  always #10 clk_sys = ~clk_sys;

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // Classic single cycle; the request holds until ack is sampled at an edge.
  task automatic wb_cycle(input logic [7:0] a, input logic w, input logic [31:0] d);
    wb_adr_i <= a;
    wb_we_i <= w;
    wb_dat_i <= d;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    // Only the watchdog ends a wait for the acknowledge.
    do begin
      @(posedge clk_sys);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic wb_chk(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    wb_cycle(a, 1'b0, 32'h0);
    check(nm, q & m, e);
  endtask
  task automatic tw_chk(input string nm, input logic [2:0] p, input logic [7:0] e);
    host.reg_read(p, sb, ok);
    check(nm, {23'h0, ok, sb}, {23'h1, e});
  endtask

  task automatic t_power();
    wb_chk("dnr_early", `MLC_WB_STAT, 32'h1, 32'h1); // Busy at first.
    check("line_early", module_irq_n_i, 1'b1); // No early flag.
    wait_clk(INIT_N + 20);
    wb_chk("dnr_clear", `MLC_WB_STAT, 32'h1, 32'h0); // Ready in time.
    wb_chk("istat_done", `MLC_WB_ISTAT, 32'h7, 32'h1); // Flag at power-up.
    check("line_done", module_irq_n_i, 1'b0); // Line low.
    check("irq_level", module_irq_n_o, 1'b0); // Pulls low only.
    check("present", module_present_n_oe ? module_present_n_o : 1'b1, 1'b0); // Grounded.
    wb_chk("thr_reset", `MLC_WB_THR, 32'hFF, 32'h20); // Default value.
    wb_chk("unmapped", 8'h1C, 32'hFFFFFFFF, 32'h0);
  endtask
  task automatic t_irq();
    wb_cycle(`MLC_WB_IMASK, 1'b1, 32'h1);
    check("irq_on", irq, 1'b1); // Unmasked flag.
    wb_cycle(`MLC_WB_IMASK, 1'b1, 32'h0);
    check("irq_masked", irq, 1'b0); // Masked flag.
    wb_cycle(`MLC_WB_IMASK, 1'b1, 32'h1);
    wb_cycle(`MLC_WB_ISTAT, 1'b1, 32'h1);
    check("irq_cleared", irq, 1'b0); // Cleared flag.
    wb_chk("istat_w1c", `MLC_WB_ISTAT, 32'h7, 32'h0); // Write one clears.
    tw_chk("flags", `MLC_TW_FLAGS, 8'h01); // Cause seen.
    wait_clk(4);
    check("line_freed", module_irq_n_i, 1'b1); // Released after read.
    tw_chk("flags_again", `MLC_TW_FLAGS, 8'h00); // Flag gone.
  endtask
  task automatic t_tx();
    transmit_disable <= 1'b1;
    wait_clk(6);
    check("tx_pin_on", tx_output_off, 1'b1); // Pin path.
    transmit_disable <= 1'b0;
    wait_clk(6);
    check("tx_pin_off", tx_output_off, 1'b0); // Pin path.
    wb_cycle(`MLC_WB_CTRL, 1'b1, 32'h1);
    wait_clk(2);
    check("tx_soft_on", tx_output_off, 1'b1); // Control bit.
    wb_cycle(`MLC_WB_CTRL, 1'b1, 32'h0);
    wait_clk(2);
    check("tx_soft_off", tx_output_off, 1'b0); // Control bit.
    host.reg_write(`MLC_TW_CTRL, 8'h01, ok);
    wait_clk(4);
    check("tx_serial_on", {ok, tx_output_off}, 2'b11); // Serial path.
    module_select_n <= 1'b1;
    wait_clk(4);
    host.reg_write(`MLC_TW_CTRL, 8'h00, ok);
    wait_clk(4);
    check("unselected", {ok, tx_output_off}, 2'b01); // Ignored traffic.
    module_select_n <= 1'b0;
    wait_clk(4);
    host.reg_write(`MLC_TW_CTRL, 8'h00, ok);
    wait_clk(4);
    check("tx_serial_off", {ok, tx_output_off}, 2'b10); // Answers again.
  endtask
  task automatic t_loss();
    rx_level_flat <= 32'h80208080;
    wait_clk(4);
    check("loss_equal", receive_signal_loss, 1'b0); // Not below.
    rx_level_flat <= 32'h801F8080;
    wait_clk(4);
    check("loss_below", receive_signal_loss, 1'b1); // One lane low.
    wb_chk("stat_lanes", `MLC_WB_STAT, 32'hF08, 32'h408); // Lane two.
    wb_chk("istat_los", `MLC_WB_ISTAT, 32'h2, 32'h2); // Event kept.
    check("line_los", module_irq_n_i, 1'b0); // Critical status.
    tw_chk("lane2_level", 3'h6, 8'h1F); // Level readable.
    tw_chk("loss_bits", `MLC_TW_LOSS, 8'h04); // Lane bits.
    tw_chk("flags_los", `MLC_TW_FLAGS, 8'h02); // Cause seen.
    rx_level_flat <= 32'h80808080;
    wait_clk(4);
    check("loss_gone", receive_signal_loss, 1'b0); // Recovered.
    check("line_los_off", module_irq_n_i, 1'b1); // Released after read.
  endtask
  task automatic t_lpm();
    low_power_request <= 1'b1;
    wait_clk(5);
    check("lp_on", power_limit_low, 1'b1); // Low limit.
    low_power_request <= 1'b0;
    wait_clk(5);
    check("lp_off", power_limit_low, 1'b0); // High limit.
  endtask
  task automatic t_mreset();
    wb_cycle(`MLC_WB_THR, 1'b1, 32'h40);
    module_reset_n <= 1'b0;
    wait_clk(RMIN_N - 3);
    module_reset_n <= 1'b1;
    wait_clk(6);
    wb_chk("thr_kept", `MLC_WB_THR, 32'hFF, 32'h40); // Too short.
    module_reset_n <= 1'b0;
    wait_clk(RMIN_N + 6);
    module_reset_n <= 1'b1;
    wait_clk(4);
    wb_chk("dnr_set", `MLC_WB_STAT, 32'h1, 32'h1); // Busy again.
    wb_chk("thr_default", `MLC_WB_THR, 32'hFF, 32'h20); // Defaults back.
    check("line_quiet", module_irq_n_i, 1'b1); // No early flag.
    wait_clk(INIT_N + 20);
    wb_chk("dnr_done", `MLC_WB_STAT, 32'h1, 32'h0); // Ready again.
    check("line_again", module_irq_n_i, 1'b0); // Completion flag.
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Main sequence after 20 cycles of reset.
  initial begin
    wait_clk(20);
    srst <= 1'b0;
    module_select_n <= 1'b0;
    t_power();
    t_irq();
    t_tx();
    t_loss();
    t_lpm();
    t_mreset();
    print_verdict();
  end

  // Watchdog well beyond the roughly 2600 cycles the sequence needs.
  initial begin
    wait_clk(20000);
    bad_count++;
    print_verdict();
  end
endmodule // mlc_ctrl_tb

/* File: mlc_host_model.sv */
// Host board model: a 2-wire bus master plus the pull-ups on the shared lines.
`timescale 1ns/1ps
module mlc_host_model #(
  parameter logic [6:0] DEV_ADDR = 7'h50
) (
  input wire logic clk_sys,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic module_irq_n_o,
  input wire logic module_irq_n_oe,
  output logic scl_in,
  output logic sda_in,
  output logic module_irq_n_i
);
  logic pull_low_r = 1'b0;
  // Host pull-ups.
  // A released line reads high, so a module that never pulls low looks idle.
  assign sda_in = ~((sda_oe & ~sda_out) | pull_low_r);
  assign module_irq_n_i = ~(module_irq_n_oe & ~module_irq_n_o);
  // The serial clock stands high between frames.
  initial scl_in = 1'b1;
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // One bit of 8 clocks; sampling sits 6 clocks after the fall to clear the module's sync delay.
  task automatic bit_io(input logic b, output logic r);
    tick(1);
    pull_low_r <= ~b;
    tick(3);
    scl_in <= 1'b1;
    tick(2);
    r = sda_in;
    tick(2);
    scl_in <= 1'b0;
  endtask
  task automatic byte_io(input logic [7:0] tx, input logic ack_bit, output logic [7:0] rx, output logic ack_seen);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], r);
      rx[i] = r;
    end
    bit_io(ack_bit, r);
    ack_seen = ~r;
  endtask
  task automatic start_cond();
    tick(1);
    pull_low_r <= 1'b1;
    tick(4);
    scl_in <= 1'b0;
  endtask
  task automatic stop_cond();
    tick(1);
    pull_low_r <= 1'b1;
    tick(3);
    scl_in <= 1'b1;
    tick(3);
    pull_low_r <= 1'b0;
    tick(4);
  endtask
  // Writes one byte at a pointer; ok is high when every byte was acknowledged.
  task automatic reg_write(input logic [2:0] ptr, input logic [7:0] d, output logic ok);
    logic [7:0] rx;
    logic a0, a1, a2;
    start_cond();
    byte_io({DEV_ADDR, 1'b0}, 1'b1, rx, a0);
    byte_io({5'h00, ptr}, 1'b1, rx, a1);
    byte_io(d, 1'b1, rx, a2);
    stop_cond();
    ok = a0 & a1 & a2;
  endtask
  // Cause lookup.
  // Reads one byte at a pointer and ends it with a not-acknowledge.
  task automatic reg_read(input logic [2:0] ptr, output logic [7:0] d, output logic ok);
    logic a0, a1, a2;
    start_cond();
    byte_io({DEV_ADDR, 1'b0}, 1'b1, d, a0);
    byte_io({5'h00, ptr}, 1'b1, d, a1);
    stop_cond();
    start_cond();
    byte_io({DEV_ADDR, 1'b1}, 1'b1, d, a2);
    ok = a0 & a1 & a2;
    byte_io(8'hFF, 1'b1, d, a0);
    stop_cond();
  endtask
endmodule // mlc_host_model

/* File: mlc_init.sv */
// Reset pin filter and initialisation timer that produces the reset-complete event.
`timescale 1ns/1ps
`include "mlc_regs.svh"
module mlc_init #(
  parameter int unsigned INIT_CYCLES = `MLC_INIT_CYC,
  parameter int unsigned RST_MIN_CYCLES = `MLC_RST_MIN_CYC
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic reset_n_s,
  output logic dev_rst,
  output logic init_done,
  output logic data_not_ready
);
  logic [31:0] low_cnt_r;
  logic [31:0] init_cnt_r;

  // Length of the current low pulse on the reset pin, saturating at the minimum.
  always_ff @(posedge clk_sys) begin
    if (srst || reset_n_s) begin
      low_cnt_r <= 32'h0;
    end else if (low_cnt_r != RST_MIN_CYCLES) begin
      low_cnt_r <= low_cnt_r + 32'h1;
    end
  end

  // Long pulse resets. A short glitch never disturbs the settings.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      dev_rst <= 1'b0;
    end else begin
      dev_rst <= !reset_n_s && (low_cnt_r == RST_MIN_CYCLES);
    end
  end

  // Power-up completion. srst stands for power-good, so power-up runs this same timer.
  // Initialisation time bound. The timer restarts after every full reset.
  always_ff @(posedge clk_sys) begin
    if (srst || dev_rst) begin
      init_cnt_r <= 32'h0;
      data_not_ready <= 1'b1;
      init_done <= 1'b0;
    end else if (data_not_ready && init_cnt_r == INIT_CYCLES - 1) begin
      data_not_ready <= 1'b0;
      init_done <= 1'b1;
    end else begin
      init_cnt_r <= data_not_ready ? init_cnt_r + 32'h1 : init_cnt_r;
      init_done <= 1'b0;
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  a_rst_min_len: assert property ($rose(dev_rst) |-> $past(low_cnt_r) == RST_MIN_CYCLES)
    else $error("Full reset taken before the minimum pulse length.");
  a_rst_not_ready: assert property (dev_rst |=> data_not_ready && !init_done)
    else $error("Data-not-ready not set by a full reset.");
  a_init_time: assert property ($fell(data_not_ready) |-> $past(init_cnt_r) == INIT_CYCLES - 1)
    else $error("Initialisation ended at the wrong count.");
endmodule // mlc_init

/* File: mlc_pkg.sv */
// Types shared by the module control block.
package mlc_pkg;
  typedef enum logic [2:0] {
    TW_IDLE = 3'b000,
    TW_DEV = 3'b001,
    TW_ACK = 3'b010,
    TW_WR = 3'b011,
    TW_RD = 3'b100,
    TW_RACK = 3'b101
  } mlc_tw_state_t;
endpackage

/* File: mlc_regs.svh */
// Offsets, field positions, reset values and timing counts of the module control block.
`ifndef MLC_REGS_SVH
`define MLC_REGS_SVH
`define MLC_WB_CTRL 8'h00
`define MLC_WB_STAT 8'h04
`define MLC_WB_ISTAT 8'h08
`define MLC_WB_IMASK 8'h0C
`define MLC_WB_THR 8'h10
`define MLC_CTRL_TXDIS 0
`define MLC_THR_RST 8'h20
`define MLC_EV_W 3
`define MLC_EV_DONE 0
`define MLC_EV_LOS 1
`define MLC_EV_HOST 2
`define MLC_HF_W 2
`define MLC_TW_STAT 3'h0
`define MLC_TW_FLAGS 3'h1
`define MLC_TW_LOSS 3'h2
`define MLC_TW_CTRL 3'h3
`define MLC_TW_ADDR 7'h50
`define MLC_CLK_NS 20
`define MLC_INIT_MS 2000
`define MLC_INIT_CYC (`MLC_INIT_MS * 1000000 / `MLC_CLK_NS)
`define MLC_RST_MIN_NS 10000
`define MLC_RST_MIN_CYC ((`MLC_RST_MIN_NS + `MLC_CLK_NS - 1) / `MLC_CLK_NS)
`endif

/* File: mlc_sync.sv */
// Two-flop synchroniser for pins that arrive from outside the clock domain.
`timescale 1ns/1ps
module mlc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '1
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_r;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      meta_r <= INIT;
      q_o <= INIT;
    end else begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end
endmodule // mlc_sync
